// ---- hdl/diag_ctrl_regs.vh ----
// Frame layout, command codes and reset values for the diagnosis block
`ifndef DIAG_CTRL_REGS_VH
`define DIAG_CTRL_REGS_VH

// ----------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------
`define FRAME_BITS      5'd16
`define BYTE_BITS       5'd7
`define OVERRUN_BITS    5'd17

// ----------------------------------------------------------------
// Command families (first nibble of a frame)
// ----------------------------------------------------------------
`define CMD_COMPACT     4'h1
`define CMD_BANK        4'h2

// ----------------------------------------------------------------
// Compact select codes (second nibble)
// ----------------------------------------------------------------
`define SEL_CLEAR       4'h0
`define SEL_VIEW1       4'h1
`define SEL_VIEW2       4'h2
`define SEL_VIEW3       4'h3

// ----------------------------------------------------------------
// Bank command codes (second nibble)
// ----------------------------------------------------------------
`define BANK_RD_A       4'h0
`define BANK_RD_B       4'h1
`define BANK_CLR_A      4'h2
`define BANK_CLR_B      4'h3

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define BANK_PATTERN    3'b001
`define CODE_OK         2'b11
`define VIEW2_FILL      2'b11
`define VIEW2_CLEARED   8'h3f
`define BANK_B_UNUSED   4'h0
`define OUT_RST         10'h000
`define ISA_RST         10'h000
`define ISB_RST         10'h000
`define OPS_RST         8'h00

`endif

// ---- hdl/spi_frame_shifter.v ----
// Sampled 16-bit SPI slave shifter with mid-frame low byte reload
`timescale 1ns/1ps
`include "diag_ctrl_regs.vh"

module spi_frame_shifter (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // SPI pins
    input  wire        cs_n_pin,
    input  wire        sclk_pin,
    input  wire        si_pin,
    output wire        so_out,
    output wire        so_oe,
    // Frame data
    input  wire [15:0] tx_word,
    input  wire [7:0]  low_byte,
    input  wire        low_load,
    output wire        frame_start,
    output wire        byte_done,
    output wire        frame_done,
    output wire [15:0] rx_word
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg         cs_meta_ff;
reg         cs_sync_ff;
reg         cs_prev_ff;
reg         sclk_meta_ff;
reg         sclk_sync_ff;
reg         sclk_prev_ff;
reg         si_meta_ff;
reg         si_sync_ff;
reg  [4:0]  count_ff;
reg  [15:0] rx_ff;
reg  [15:0] tx_ff;
reg         byte_ff;
reg         oe_ff;
wire        active;
wire        sclk_rise;
wire        sclk_fall;

// Two flops per pin; SI delayed like SCLK so they stay aligned
always @(posedge ref_clk) begin
    if (srst) begin
        cs_meta_ff   <= 1'b1;
        cs_sync_ff   <= 1'b1;
        cs_prev_ff   <= 1'b1;
        sclk_meta_ff <= 1'b0;
        sclk_sync_ff <= 1'b0;
        sclk_prev_ff <= 1'b0;
        si_meta_ff   <= 1'b0;
        si_sync_ff   <= 1'b0;
    end else begin
        cs_meta_ff   <= cs_n_pin;
        cs_sync_ff   <= cs_meta_ff;
        cs_prev_ff   <= cs_sync_ff;
        sclk_meta_ff <= sclk_pin;
        sclk_sync_ff <= sclk_meta_ff;
        sclk_prev_ff <= sclk_sync_ff;
        si_meta_ff   <= si_pin;
        si_sync_ff   <= si_meta_ff;
    end
end

// Edge detection on synchronised levels only
assign active      = ~cs_sync_ff;
assign sclk_rise   = active & sclk_sync_ff & ~sclk_prev_ff;
assign sclk_fall   = active & ~sclk_sync_ff & sclk_prev_ff;
assign frame_start = cs_prev_ff & ~cs_sync_ff;
assign frame_done  = ~cs_prev_ff & cs_sync_ff & (count_ff == `FRAME_BITS);

// ----------------------------------------------------------------
// Shift registers
// ----------------------------------------------------------------
// Full-duplex shift
always @(posedge ref_clk) begin
    if (srst) begin
        count_ff <= 5'd0;
        rx_ff    <= 16'h0000;
        tx_ff    <= 16'h0000;
        byte_ff  <= 1'b0;
        oe_ff    <= 1'b0;
    end else begin
        oe_ff   <= active;
        byte_ff <= sclk_rise & (count_ff == `BYTE_BITS);
        if (frame_start) begin
            count_ff <= 5'd0;
            rx_ff    <= 16'h0000;
            tx_ff    <= tx_word;
        end else begin
            // Count stops past 16 so overlong frames are dropped
            if (sclk_rise) begin
                rx_ff <= {rx_ff[14:0], si_sync_ff};
                if (count_ff != `OVERRUN_BITS)
                    count_ff <= count_ff + 5'd1;
            end
            // Reload after 7 shifts, so bit 7 appears next fall
            if (low_load)
                tx_ff[14:7] <= low_byte;
            else if (sclk_fall && count_ff != 5'd0)
                tx_ff <= {tx_ff[14:0], 1'b0};
        end
    end
end

assign so_out    = tx_ff[15];
assign so_oe     = oe_ff;
assign byte_done = byte_ff;
assign rx_word   = rx_ff;

endmodule // spi_frame_shifter

// ---- hdl/spi_diag_compact_control.v ----
// Diagnosis banks, compact control commands and SPI response builder
`timescale 1ns/1ps
`include "diag_ctrl_regs.vh"

// Function
// - Compact command selects a diagnosis view and sets pins of ch 7-10.
// - Pin-set bits 3:0 pick parallel (1) or serial (0) per channel.
// - Pin-set bits 7:4 switch channels 7 to 10 on (1) or off (0).
// - Pin-set byte updates source banks and switch register, also kept for feedback.
// - Per-channel code: 11 ok, 10 on-fault, 01 open, 00 short; default 11.
// - A new fault code overwrites the stored code of that channel.
// - Sent diagnosis is latched at chip select fall of its frame.
// - Bank answer: parity bit 15, 001 in 14:12, bank in 11:0.
// - Every received frame is answered by a full simultaneous frame.
// - First received byte picks second response byte of same frame.
// - Second received byte picks first response byte of next frame.
// - View 2 bits 7:6 flag any fault stored in views 1 and 3.
// - Feedback echoes previous on/off bit or pin level at select fall.
// - Clear command empties both banks; present faults return at once.
module spi_diag_compact_control (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // SPI pins
    input  wire        cs_n_pin,
    input  wire        sclk_pin,
    input  wire        si_pin,
    output wire        so_out,
    output wire        so_oe,
    // Fault detectors, same clock domain
    input  wire [9:0]  fault_valid,
    input  wire [19:0] fault_code,
    // Parallel input pins of channels 7 to 10
    input  wire [3:0]  in_pin,
    // Channel control state
    output wire [9:0]  channel_switch_register,
    output wire [9:0]  source_select_bank_a,
    output wire [9:0]  source_select_bank_b,
    // Diagnosis state
    output wire [11:0] diag_status_bank_a,
    output wire [11:0] diag_status_bank_b
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
localparam [1:0] RESP_NONE     = 2'd0;
localparam [1:0] RESP_FEEDBACK = 2'd1;
localparam [1:0] RESP_BANK_A   = 2'd2;
localparam [1:0] RESP_BANK_B   = 2'd3;

reg  [1:0]  resp_ff;
reg  [1:0]  nxt_resp;
reg  [1:0]  pend_clr_ff;
reg  [1:0]  nxt_pend_clr;
reg  [7:0]  last_ops_ff;
reg  [7:0]  nxt_last_ops;
reg  [9:0]  sw_ff;
reg  [9:0]  nxt_sw;
reg  [9:0]  isa_ff;
reg  [9:0]  nxt_isa;
reg  [9:0]  isb_ff;
reg  [9:0]  nxt_isb;
reg  [19:0] snap_ff;
reg  [3:0]  pin_meta_ff;
reg  [3:0]  pin_sync_ff;
reg  [15:0] tx_word;
reg  [7:0]  low_byte;
reg         low_load;
reg         clr_a;
reg         clr_b;
wire [19:0] codes;
wire [11:0] bank_a;
wire [11:0] bank_b;
wire [3:0]  fb_bits;
wire [7:0]  feedback;
wire        frame_start;
wire        byte_done;
wire        frame_done;
wire [15:0] rx_word;
wire [3:0]  first_family;
wire [3:0]  first_sel;

// ----------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------
// A channel is fault free only when both code bits are one
function any_fault;
    input [7:0] view;
    begin
        any_fault = ~&view;
    end
endfunction

// Builds one of the three output views from a bank snapshot
function [7:0] view_of;
    input [3:0]  sel;
    input [19:0] snap;
    begin
        case (sel)
            `SEL_VIEW1: view_of = snap[7:0];
            `SEL_VIEW2: view_of = {any_fault(snap[7:0]),
                                   any_fault(snap[19:12]),
                                   `VIEW2_FILL, snap[11:8]};
            `SEL_VIEW3: view_of = snap[19:12];
            default:    view_of = 8'h00;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// Serial engine
// ----------------------------------------------------------------
spi_frame_shifter u_shifter (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .cs_n_pin    (cs_n_pin),
    .sclk_pin    (sclk_pin),
    .si_pin      (si_pin),
    .so_out      (so_out),
    .so_oe       (so_oe),
    .tx_word     (tx_word),
    .low_byte    (low_byte),
    .low_load    (low_load),
    .frame_start (frame_start),
    .byte_done   (byte_done),
    .frame_done  (frame_done),
    .rx_word     (rx_word)
);

assign first_family = rx_word[7:4];
assign first_sel    = rx_word[3:0];

// ----------------------------------------------------------------
// Diagnosis banks
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 10; g = g + 1) begin : chan
        reg  [1:0] code_ff;
        wire       clr_this;
        // Channels 1-6 live in bank A, 7-10 in bank B
        assign clr_this = (g < 6) ? clr_a : clr_b;
        // New fault overwrites; set beats clear
        always @(posedge ref_clk) begin
            if (srst)
                code_ff <= `CODE_OK;
            else if (fault_valid[g])
                code_ff <= fault_code[2*g+1:2*g];
            else if (clr_this)
                code_ff <= `CODE_OK;
        end
        assign codes[2*g+1:2*g] = code_ff;
    end
endgenerate

assign bank_a = codes[11:0];
// Unused upper bits of bank B
assign bank_b = {`BANK_B_UNUSED, codes[19:12]};

// ----------------------------------------------------------------
// Parallel pin sampling
// ----------------------------------------------------------------
// Pins come from outside, two flops before use
always @(posedge ref_clk) begin
    if (srst) begin
        pin_meta_ff <= 4'h0;
        pin_sync_ff <= 4'h0;
    end else begin
        pin_meta_ff <= in_pin;
        pin_sync_ff <= pin_meta_ff;
    end
end

// Parallel channels echo pins, serial ones the last on/off bits
assign fb_bits  = (last_ops_ff[3:0] & pin_sync_ff) |
                  (~last_ops_ff[3:0] & last_ops_ff[7:4]);
assign feedback = {fb_bits, last_ops_ff[3:0]};

// ----------------------------------------------------------------
// Response word loaded at chip select fall
// ----------------------------------------------------------------
// First byte set by the previous frame's command
always @* begin
    case (resp_ff)
        RESP_FEEDBACK: tx_word = {feedback, 8'h00};
        RESP_BANK_A:   tx_word = {^{`BANK_PATTERN, bank_a},
                                  `BANK_PATTERN, bank_a};
        RESP_BANK_B:   tx_word = {^{`BANK_PATTERN, bank_b},
                                  `BANK_PATTERN, bank_b};
        default:       tx_word = 16'h0000;
    endcase
end

// ----------------------------------------------------------------
// Mid-frame decode of the first byte
// ----------------------------------------------------------------
// First byte chooses the low byte of this frame
always @* begin
    low_load = byte_done & (first_family == `CMD_COMPACT);
    if (first_sel == `SEL_CLEAR)
        low_byte = `VIEW2_CLEARED;
    else
        low_byte = view_of(first_sel, snap_ff);
end

// Clears: compact clear mid-frame, bank clears at the next select fall as the answer loads
always @* begin
    clr_a = 1'b0;
    clr_b = 1'b0;
    if (low_load && first_sel == `SEL_CLEAR) begin
        clr_a = 1'b1;
        clr_b = 1'b1;
    end
    // Old contents went out in this frame's load, so clear now
    if (frame_start) begin
        clr_a = clr_a | pend_clr_ff[0];
        clr_b = clr_b | pend_clr_ff[1];
    end
end

// ----------------------------------------------------------------
// End-of-frame command decode
// ----------------------------------------------------------------
always @* begin
    nxt_resp     = resp_ff;
    nxt_pend_clr = pend_clr_ff;
    nxt_last_ops = last_ops_ff;
    nxt_sw       = sw_ff;
    nxt_isa      = isa_ff;
    nxt_isb      = isb_ff;
    if (frame_start)
        nxt_pend_clr = 2'b00;
    if (frame_done) begin
        case (rx_word[15:12])
            `CMD_COMPACT: begin
                // Pin-set byte steers channels 7 to 10
                nxt_resp     = RESP_FEEDBACK;
                nxt_last_ops = rx_word[7:0];
                // On/off bits into the switch register
                nxt_sw[9:6]  = rx_word[7:4];
                // Parallel sets source code 10, serial 00
                nxt_isb[9:6] = rx_word[3:0];
                nxt_isa[9:6] = 4'h0;
            end
            `CMD_BANK: begin
                case (rx_word[11:8])
                    `BANK_RD_A:  nxt_resp = RESP_BANK_A;
                    `BANK_RD_B:  nxt_resp = RESP_BANK_B;
                    `BANK_CLR_A: begin
                        nxt_resp     = RESP_BANK_A;
                        nxt_pend_clr = 2'b01;
                    end
                    `BANK_CLR_B: begin
                        nxt_resp     = RESP_BANK_B;
                        nxt_pend_clr = 2'b10;
                    end
                    default:     nxt_resp = RESP_NONE;
                endcase
            end
            default: nxt_resp = RESP_NONE;
        endcase
    end
end

// ----------------------------------------------------------------
// State registers
// ----------------------------------------------------------------
// Pin-set byte lands in the control banks and in last_ops_ff
always @(posedge ref_clk) begin
    if (srst) begin
        resp_ff     <= RESP_NONE;
        pend_clr_ff <= 2'b00;
        last_ops_ff <= `OPS_RST;
        sw_ff       <= `OUT_RST;
        isa_ff      <= `ISA_RST;
        isb_ff      <= `ISB_RST;
    end else begin
        resp_ff     <= nxt_resp;
        pend_clr_ff <= nxt_pend_clr;
        last_ops_ff <= nxt_last_ops;
        sw_ff       <= nxt_sw;
        isa_ff      <= nxt_isa;
        isb_ff      <= nxt_isb;
    end
end

// Views frozen at select fall for the whole frame
always @(posedge ref_clk) begin
    if (srst)
        snap_ff <= {10{`CODE_OK}};
    else if (frame_start)
        snap_ff <= codes;
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign channel_switch_register = sw_ff;
assign source_select_bank_a    = isa_ff;
assign source_select_bank_b    = isb_ff;
assign diag_status_bank_a      = bank_a;
assign diag_status_bank_b      = bank_b;

endmodule // spi_diag_compact_control

// ---- dv/diag_ctrl_checker.sv ----
// Assertion checker for the diagnosis and compact control block
`timescale 1ns/1ps
module diag_ctrl_checker (
    // Clock and reset
    input wire        ref_clk,
    input wire        srst,
    // Select pin and output enable
    input wire        cs_n_pin,
    input wire        so_oe,
    // Fault reports
    input wire [9:0]  fault_valid,
    input wire [19:0] fault_code,
    // Held state
    input wire [9:0]  channel_switch_register,
    input wire [9:0]  source_select_bank_a,
    input wire [11:0] diag_status_bank_a,
    input wire [11:0] diag_status_bank_b
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // codes start ok
    property p_rst_val;
        $fell(srst) |-> diag_status_bank_a == 12'hfff &&
            diag_status_bank_b == 12'h0ff && channel_switch_register == 10'h0;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset value");
    property p_fault_a;
        fault_valid[0] |=> diag_status_bank_a[1:0] == $past(fault_code[1:0]);
    endproperty
    a_fault_a: assert property (p_fault_a) else $error("ch1 code");
    property p_fault_b;
        fault_valid[6] |=> diag_status_bank_b[1:0] == $past(fault_code[13:12]);
    endproperty
    a_fault_b: assert property (p_fault_b) else $error("ch7 code");
    property p_b_top;
        diag_status_bank_b[11:8] == 4'h0;
    endproperty
    a_b_top: assert property (p_b_top) else $error("bank b top");
    property p_oe_off;
        cs_n_pin [*4] |-> !so_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("so driven idle");
    property p_oe_on;
        !cs_n_pin [*4] |-> so_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("so not driven");
    property p_sw_hold;
        !cs_n_pin [*8] |=> $stable(channel_switch_register);
    endproperty
    a_sw_hold: assert property (p_sw_hold)
        else $error("switch mid frame");
    property p_src_a;
        source_select_bank_a[9:6] == 4'h0;
    endproperty
    a_src_a: assert property (p_src_a) else $error("bank a source");
    property p_bank_idle;
        (cs_n_pin [*8] ##0 fault_valid == 10'h0) |=>
            $stable(diag_status_bank_a);
    endproperty
    a_bank_idle: assert property (p_bank_idle)
        else $error("bank a drift");
endmodule // diag_ctrl_checker

bind spi_diag_compact_control diag_ctrl_checker u_chk (.ref_clk, .srst,
    .cs_n_pin, .so_oe, .fault_valid, .fault_code, .channel_switch_register,
    .source_select_bank_a, .diag_status_bank_a, .diag_status_bank_b);

// ---- dv/spi_master_model.sv ----
// Behavioural SPI master standing in for the microcontroller
`timescale 1ns/1ps
module spi_master_model (
    // Clock
    input  wire  ref_clk,
    // SPI pins
    input  wire  so_out,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic si_pin
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        si_pin = 1'b0;
    end

    task automatic xfer(input logic [16:0] tx, input int n,
                        output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        @(negedge ref_clk);
        cs_n_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (i = n - 1; i >= 0; i--) begin
            si_pin = tx[i];
            repeat (4) @(negedge ref_clk);
            sclk_pin = 1'b1;
            repeat (4) @(negedge ref_clk);
            // Sampled at the fall, SO only moves later
            rx = {rx[14:0], so_out};
            sclk_pin = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        cs_n_pin = 1'b1;
        // Released line, no pull: show a changed level
        si_pin = ~si_pin;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule // spi_master_model

// ---- dv/spi_diag_compact_control_test.sv ----
// Self-checking bench for the diagnosis and compact control block
`timescale 1ns/1ps
`include "diag_ctrl_regs.vh"
module spi_diag_compact_control_test;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [9:0]  fault_valid = 10'h000;
    logic [19:0] fault_code = 20'h00000;
    logic [3:0]  in_pin = 4'h0;
    logic [15:0] rx;
    wire         cs_n_pin, sclk_pin, si_pin, so_out, so_oe;
    wire  [9:0]  channel_switch_register, source_select_bank_a;
    wire  [9:0]  source_select_bank_b;
    wire  [11:0] diag_status_bank_a, diag_status_bank_b;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    // Clock and hang guard, a run needs about 1800 cycles
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    spi_diag_compact_control u_dut (.ref_clk, .srst, .cs_n_pin, .sclk_pin,
        .si_pin, .so_out, .so_oe, .fault_valid, .fault_code, .in_pin,
        .channel_switch_register, .source_select_bank_a,
        .source_select_bank_b, .diag_status_bank_a, .diag_status_bank_b);
    spi_master_model u_mst (.ref_clk, .so_out, .cs_n_pin, .sclk_pin,
        .si_pin);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task frame(input logic [15:0] tx, input int n = 16);
        // A seventeenth clock sends a leading zero first
        u_mst.xfer({1'b0, tx}, n, rx);
    endtask
    task pulse(input int ch, input logic [1:0] code);
        @(negedge ref_clk);
        fault_code[2*ch +: 2] = code;
        fault_valid[ch] = 1'b1;
        @(negedge ref_clk);
        fault_valid = 10'h000;
    endtask
    // Parity, pattern and bank as sent back for a bank command
    function automatic logic [15:0] bank_word(input logic [11:0] b);
        return {^{3'b001, b}, 3'b001, b};
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_pinset;
        chk("bank a rst", 16'(12'hfff), 16'(diag_status_bank_a));
        chk("bank b rst", 16'(12'h0ff), 16'(diag_status_bank_b));
        in_pin = 4'b0011;
        frame({`CMD_COMPACT, `SEL_VIEW1, 8'hc5});
        chk("view1 resp", 16'h00ff, rx);
        chk("switch", 16'h000c, 16'(channel_switch_register[9:6]));
        chk("src b", 16'h0005, 16'(source_select_bank_b[9:6]));
        chk("src a", 16'h0000, 16'(source_select_bank_a[9:6]));
        frame({`CMD_COMPACT, `SEL_VIEW3, 8'h00});
        chk("feedback", 16'h95ff, rx);
    endtask
    task t_fault;
        frame({`CMD_COMPACT, `SEL_VIEW2, 8'h00});
        chk("view2 clean", 16'h003f, rx);
        pulse(0, 2'b10);
        pulse(6, 2'b00);
        chk("bank a fault", 16'(12'hffe), 16'(diag_status_bank_a));
        chk("bank b fault", 16'(12'h0fc), 16'(diag_status_bank_b));
        pulse(0, 2'b01);
        chk("overwrite", 16'(12'hffd), 16'(diag_status_bank_a));
        frame({`CMD_COMPACT, `SEL_VIEW2, 8'h00});
        chk("view2 flags", 16'h00ff, rx);
    endtask
    task t_bank;
        frame({`CMD_BANK, `BANK_RD_A, 8'h00});
        // A fault mid frame must not reach the word being sent
        fork
            frame({`CMD_BANK, `BANK_RD_B, 8'h00});
            begin
                repeat (60) @(negedge ref_clk);
                pulse(0, 2'b11);
            end
        join
        chk("read a", bank_word(12'hffd), rx);
        frame({`CMD_BANK, `BANK_CLR_B, 8'h00});
        chk("read b", bank_word(12'h0fc), rx);
        frame({`CMD_BANK, `BANK_RD_A, 8'h00});
        chk("clear b resp", bank_word(12'h0fc), rx);
        chk("b cleared", 16'(12'h0ff), 16'(diag_status_bank_b));
    endtask
    task t_clear;
        pulse(2, 2'b01);
        pulse(9, 2'b10);
        frame({`CMD_COMPACT, `SEL_CLEAR, 8'h00});
        chk("clear resp", 16'h003f, 16'(rx[7:0]));
        chk("a clear", 16'(12'hfff), 16'(diag_status_bank_a));
        chk("b clear", 16'(12'h0ff), 16'(diag_status_bank_b));
        // Seventeen clocks: the frame must be dropped
        frame({`CMD_COMPACT, `SEL_VIEW1, 8'hf0}, 17);
        chk("long frame", 16'h0000, 16'(channel_switch_register));
        // Bank A clear answers with the old contents, then empties
        pulse(1, 2'b00);
        frame({`CMD_BANK, `BANK_CLR_A, 8'h00});
        chk("after long", 16'h0000, rx);
        frame({`CMD_BANK, `BANK_RD_B, 8'h00});
        chk("clear a resp", bank_word(12'hff3), rx);
        chk("a cleared", 16'(12'hfff), 16'(diag_status_bank_a));
    endtask

    // ----------------------------------------------------------------
    // Verdict and main sequence
    // ----------------------------------------------------------------
    task wrap_up;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_pinset();
        t_fault();
        t_bank();
        t_clear();
        wrap_up();
    end
endmodule // spi_diag_compact_control_test
